// ===== sil_pkg.sv
// Package with constants and carrier types for the status indicator logic.
package sil_pkg;

   // ======================================================================
   // Register map
   // ======================================================================
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COND = 4'h1;
   localparam logic [3:0] ADDR_LAMP = 4'h2;
   localparam logic [3:0] ADDR_CFG = 4'h3;

   // Control register fields.
   localparam int CTRL_OPER = 0;
   localparam int CTRL_DUAL = 1;
   localparam int CTRL_ROUTER = 2;
   localparam int CTRL_FRMODE = 3;
   localparam int CTRL_FAULT = 4;
   localparam int CTRL_ACK = 5;

   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // ======================================================================
   // Timing
   // ======================================================================
   localparam int CLK_HZ = 20_000_000;
   localparam int BLINK_MS = 500;
   localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int OOF_MS = 1000;
   localparam int OOF_PERIOD_CYC = CLK_HZ / 1000 * OOF_MS;

   // ======================================================================
   // Carriers
   // ======================================================================
   typedef struct packed {
      logic los;
      logic loss_of_frame;
      logic oof;
      logic excess_error_rate;
      logic yellow;
      logic ais;
   } sil_line_type;

   typedef struct packed {
      logic enabled;
      logic active;
      logic mon_dtr;
      logic mon_rts;
      logic dtr;
      logic rts;
      logic txd;
      logic rxd;
   } sil_port_type;

   typedef struct packed {
      logic sig;
      logic oof;
      logic alm;
   } sil_line_lamp_type;

   typedef enum logic [1:0] {
      SIL_BKP_OFF = 2'b00,
      SIL_BKP_SETUP = 2'b01,
      SIL_BKP_ON = 2'b10
   } sil_bkp_type;

endpackage

// ===== sil_status_indicator.sv
// Status indicator logic: condition flags to lamps and screen indicators.
//
// Function
// - Alarm lamp lit after reset and on faults
// - Alarm lamp dark only with no failure
// - Test lamp lit while any test runs
// - Backup lamp steady when backup traffic flows
// - Backup lamp blinks while alternate link sets up
// - Dual model: mode lamp yellow when link management down
// - Mode screen indicator on in frame relay
// - Signal lamp lit while signal recoverable
// - Out-of-frame lamp shows last sampling period
// - Line alarm lamp is OR of six
// - Port ready when leads are correct
// - Port dark when disabled or monitored lead low
// - Dual model: lit if either enabled port active
// - Dual model: both enabled, one inactive, dark
// - LAN ready lamp lit while transferring
// - Link management indicator on when protocol good
// - TXD indicator shows transmit activity
// - RXD indicator shows receive activity
// - DTR indicator mirrors DTR lead
// - RTS indicator mirrors RTS lead
// - Line and port ready screen indicators equal their lamps
// - Power lamp lit only when operational
`timescale 1ns/1ps
`default_nettype none

module sil_status_indicator #(
   parameter int NLINE = 2,
   parameter int BLINK_HALF = sil_pkg::BLINK_HALF_CYC,
   parameter int OOF_PERIOD = sil_pkg::OOF_PERIOD_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Conditions from the rest of the unit.
   input wire logic fault_any,
   input wire logic test_any,
   input wire logic backup_up,
   input wire logic backup_data,
   input wire logic link_mgmt_good,
   input wire sil_pkg::sil_line_type [NLINE-1:0] line_cond,
   input wire sil_pkg::sil_port_type port0,
   input wire sil_pkg::sil_port_type port1,
   input wire logic lan_tx,
   input wire logic lan_rx,
   // Lamps.
   output logic power_lamp,
   output logic alarm_lamp,
   output logic test_active_lamp,
   output logic backup_lamp,
   output logic frame_relay_mode_lamp,
   output logic mode_lamp_green,
   output sil_pkg::sil_line_lamp_type [NLINE-1:0] line_lamp,
   output logic port_ready_lamp,
   // Screen indicators.
   output logic scr_frame_relay_mode,
   output logic scr_link_mgmt_good,
   output sil_pkg::sil_line_lamp_type [NLINE-1:0] scr_line,
   output logic scr_port_ready,
   output logic scr_txd,
   output logic scr_rxd,
   output logic scr_dtr,
   output logic scr_rts
);

   // ======================================================================
   // Functions
   // ======================================================================
   function automatic logic port_ok(input sil_pkg::sil_port_type p);
      port_ok = p.enabled && p.active && !(p.mon_dtr && !p.dtr) &&
         !(p.mon_rts && !p.rts);
   endfunction

   function automatic logic line_alarm(input sil_pkg::sil_line_type c);
      line_alarm = c.los | c.loss_of_frame | c.oof | c.excess_error_rate | c.yellow | c.ais;
   endfunction

   // ======================================================================
   // Registers
   // ======================================================================
   logic [7:0] ctrl_r;
   logic [7:0] cfg_r;
   logic reset_seen_r;

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_r <= sil_pkg::CTRL_RESET;
         cfg_r <= sil_pkg::CFG_RESET;
      end else if (reg_wr) begin
         if (reg_addr == sil_pkg::ADDR_CTRL) begin
            ctrl_r <= reg_wdata;
         end
         if (reg_addr == sil_pkg::ADDR_CFG) begin
            cfg_r <= reg_wdata;
         end
      end
   end

   // The after-reset alarm stays until software acknowledges it.
   always_ff @(posedge mclk) begin
      if (reset) begin
         reset_seen_r <= 1'b1;
      end else if (reg_wr && reg_addr == sil_pkg::ADDR_CTRL &&
            reg_wdata[sil_pkg::CTRL_ACK]) begin
         reset_seen_r <= 1'b0;
      end
   end

   wire logic dual = ctrl_r[sil_pkg::CTRL_DUAL];
   wire logic router = ctrl_r[sil_pkg::CTRL_ROUTER];

   // ======================================================================
   // Blink divider
   // ======================================================================
   // The divider runs freely from reset, so the blink phase is not tied to
   // the moment the alternate link starts to come up.
   logic [31:0] blink_cnt_r;
   logic blink_tick;
   logic blink_r;

   assign blink_tick = (blink_cnt_r >= 32'(BLINK_HALF - 1));

   always_ff @(posedge mclk) begin
      if (reset) begin
         blink_cnt_r <= 32'h0000_0000;
      end else if (blink_tick) begin
         blink_cnt_r <= 32'h0000_0000;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
   end

   // One toggle per half period gives a square wave of the full period.
   always_ff @(posedge mclk) begin
      if (reset) begin
         blink_r <= 1'b0;
      end else if (blink_tick) begin
         blink_r <= ~blink_r;
      end
   end

   sil_pkg::sil_bkp_type bkp_state;
   always_comb begin
      case ({backup_up, backup_data})
         2'b11: bkp_state = sil_pkg::SIL_BKP_ON;
         2'b10: bkp_state = sil_pkg::SIL_BKP_SETUP;
         default: bkp_state = sil_pkg::SIL_BKP_OFF;
      endcase
   end

   // ======================================================================
   // Out-of-frame sampling
   // ======================================================================
   logic [31:0] oof_cnt_r;
   logic oof_tick;
   logic [NLINE-1:0] oof_seen_r;
   logic [NLINE-1:0] oof_last_r;

   assign oof_tick = (oof_cnt_r >= 32'(OOF_PERIOD - 1));

   always_ff @(posedge mclk) begin
      if (reset) begin
         oof_cnt_r <= 32'h0000_0000;
      end else if (oof_tick) begin
         oof_cnt_r <= 32'h0000_0000;
      end else begin
         oof_cnt_r <= oof_cnt_r + 32'h0000_0001;
      end
   end

   // The latch collects events inside one period and is emptied at its end.
   always_ff @(posedge mclk) begin
      if (reset) begin
         oof_seen_r <= '0;
      end else begin
         for (int i = 0; i < NLINE; i++) begin
            if (oof_tick) begin
               oof_seen_r[i] <= 1'b0;
            end else if (line_cond[i].oof) begin
               oof_seen_r[i] <= 1'b1;
            end
         end
      end
   end

   // An event in the boundary cycle still counts for the period that ends.
   always_ff @(posedge mclk) begin
      if (reset) begin
         oof_last_r <= '0;
      end else if (oof_tick) begin
         for (int i = 0; i < NLINE; i++) begin
            oof_last_r[i] <= oof_seen_r[i] | line_cond[i].oof;
         end
      end
   end

   // ======================================================================
   // Lamp outputs
   // ======================================================================
   logic any_line_alarm;
   logic port_ready;
   always_comb begin
      any_line_alarm = 1'b0;
      for (int i = 0; i < NLINE; i++) begin
         any_line_alarm = any_line_alarm | line_alarm(line_cond[i]);
      end
      if (router) begin
         port_ready = lan_tx && lan_rx;
      end else if (!dual) begin
         port_ready = port_ok(port0);
      end else if (port0.enabled && port1.enabled) begin
         port_ready = port_ok(port0) && port_ok(port1);
      end else begin
         port_ready = port_ok(port0) || port_ok(port1);
      end
   end

   // The power lamp stays dark until software declares the unit operational.
   always_ff @(posedge mclk) begin
      if (reset) begin
         power_lamp <= 1'b0;
      end else begin
         power_lamp <= ctrl_r[sil_pkg::CTRL_OPER] && !ctrl_r[sil_pkg::CTRL_FAULT];
      end
   end

   // The alarm lamp is lit during reset, so it never shows a false all-clear.
   always_ff @(posedge mclk) begin
      if (reset) begin
         alarm_lamp <= 1'b1;
      end else begin
         alarm_lamp <= reset_seen_r || fault_any || any_line_alarm ||
            ctrl_r[sil_pkg::CTRL_FAULT];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         test_active_lamp <= 1'b0;
      end else begin
         test_active_lamp <= test_any;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         backup_lamp <= 1'b0;
      end else begin
         case (bkp_state)
            sil_pkg::SIL_BKP_ON: backup_lamp <= 1'b1;
            sil_pkg::SIL_BKP_SETUP: backup_lamp <= blink_r;
            default: backup_lamp <= 1'b0;
         endcase
      end
   end

   // The two-colour mode lamp exists only on the dual-port model.
   always_ff @(posedge mclk) begin
      if (reset) begin
         frame_relay_mode_lamp <= 1'b0;
         mode_lamp_green <= 1'b0;
      end else begin
         frame_relay_mode_lamp <= dual && !link_mgmt_good;
         mode_lamp_green <= dual && link_mgmt_good;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         scr_frame_relay_mode <= 1'b0;
         scr_link_mgmt_good <= 1'b0;
      end else begin
         scr_frame_relay_mode <= ctrl_r[sil_pkg::CTRL_FRMODE];
         scr_link_mgmt_good <= link_mgmt_good;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         line_lamp <= '0;
      end else begin
         for (int i = 0; i < NLINE; i++) begin
            line_lamp[i].sig <= !line_cond[i].los;
            line_lamp[i].oof <= oof_last_r[i];
            line_lamp[i].alm <= line_alarm(line_cond[i]);
         end
      end
   end

   // The screen copies are built from the same sources in the same cycle,
   // so a lamp and its screen indicator can never disagree.
   always_ff @(posedge mclk) begin
      if (reset) begin
         scr_line <= '0;
      end else begin
         for (int i = 0; i < NLINE; i++) begin
            scr_line[i].sig <= !line_cond[i].los;
            scr_line[i].oof <= oof_last_r[i];
            scr_line[i].alm <= line_alarm(line_cond[i]);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         port_ready_lamp <= 1'b0;
         scr_port_ready <= 1'b0;
      end else begin
         port_ready_lamp <= port_ready;
         scr_port_ready <= port_ready;
      end
   end

   // Data activity of the first user data port.
   always_ff @(posedge mclk) begin
      if (reset) begin
         scr_txd <= 1'b0;
         scr_rxd <= 1'b0;
      end else begin
         scr_txd <= port0.txd;
         scr_rxd <= port0.rxd;
      end
   end

   // Live levels of the control leads of the first user data port.
   always_ff @(posedge mclk) begin
      if (reset) begin
         scr_dtr <= 1'b0;
         scr_rts <= 1'b0;
      end else begin
         scr_dtr <= port0.dtr;
         scr_rts <= port0.rts;
      end
   end

   // ======================================================================
   // Read port
   // ======================================================================
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            sil_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
            sil_pkg::ADDR_CFG: reg_rdata <= cfg_r;
            sil_pkg::ADDR_COND: reg_rdata <= {reset_seen_r, fault_any, test_any,
               backup_up, backup_data, link_mgmt_good, any_line_alarm, port_ready};
            sil_pkg::ADDR_LAMP: reg_rdata <= {power_lamp, alarm_lamp,
               test_active_lamp, backup_lamp, frame_relay_mode_lamp,
               mode_lamp_green, port_ready_lamp, scr_frame_relay_mode};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// ===== sil_status_indicator_assertions.sv
// Checker for the status indicator outputs.
`timescale 1ns/1ps
`default_nettype none
module sil_status_indicator_assertions #(
   parameter int NLINE = 2,
   parameter int BLINK_HALF = 4,
   parameter int OOF_PERIOD = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic fault_any,
   input wire logic test_any,
   input wire logic backup_up,
   input wire logic backup_data,
   input wire logic link_mgmt_good,
   input wire sil_pkg::sil_line_type [NLINE-1:0] line_cond,
   input wire sil_pkg::sil_port_type port0,
   input wire logic alarm_lamp,
   input wire logic test_active_lamp,
   input wire logic backup_lamp,
   input wire sil_pkg::sil_line_lamp_type [NLINE-1:0] line_lamp,
   input wire logic port_ready_lamp,
   input wire logic scr_link_mgmt_good,
   input wire sil_pkg::sil_line_lamp_type [NLINE-1:0] scr_line,
   input wire logic scr_port_ready,
   input wire logic scr_txd,
   input wire logic scr_rxd,
   input wire logic scr_dtr,
   input wire logic scr_rts
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Past values are trusted only once an edge outside reset has passed.
   logic run_r;
   logic lamp_r;
   int stay_r;
   always_ff @(posedge mclk) begin
      run_r <= !reset;
      lamp_r <= backup_lamp;
      if (reset || !backup_up || backup_data || backup_lamp != lamp_r) begin
         stay_r <= 0;
      end else begin
         stay_r <= stay_r + 1;
      end
   end
   fault_alarm_a: assert property (fault_any |=> alarm_lamp)
      else $error("alarm lamp dark under fault");
   test_lamp_a: assert property (run_r |-> test_active_lamp == $past(test_any))
      else $error("test lamp wrong");
   backup_steady_a: assert property (backup_up && backup_data |=> backup_lamp)
      else $error("backup lamp not steady");
   backup_off_a: assert property (!backup_up |=> !backup_lamp)
      else $error("backup lamp lit outside backup");
   backup_blink_a: assert property (stay_r <= 2 * BLINK_HALF + 2)
      else $error("backup lamp does not blink");
   line_alarm_a: assert property (run_r |-> line_lamp[0].alm == |$past(line_cond[0]))
      else $error("line alarm lamp wrong");
   line_sig_a: assert property (run_r |-> line_lamp[1].sig == !$past(line_cond[1].los))
      else $error("signal lamp wrong");
   screen_same_a: assert property (scr_line == line_lamp && scr_port_ready == port_ready_lamp)
      else $error("screen differs from lamp");
   lead_mirror_a: assert property (run_r |-> {scr_txd, scr_rxd, scr_dtr, scr_rts} ==
      $past({port0.txd, port0.rxd, port0.dtr, port0.rts}))
      else $error("lead indicators wrong");
   link_down_a: assert property (!link_mgmt_good |=> !scr_link_mgmt_good)
      else $error("link indicator on while down");
endmodule
bind sil_status_indicator sil_status_indicator_assertions #(
   .NLINE(NLINE), .BLINK_HALF(BLINK_HALF), .OOF_PERIOD(OOF_PERIOD)
) u_chk (
   .mclk(mclk), .reset(reset), .fault_any(fault_any), .test_any(test_any),
   .backup_up(backup_up), .backup_data(backup_data), .link_mgmt_good(link_mgmt_good),
   .line_cond(line_cond), .port0(port0), .alarm_lamp(alarm_lamp),
   .test_active_lamp(test_active_lamp), .backup_lamp(backup_lamp), .line_lamp(line_lamp),
   .port_ready_lamp(port_ready_lamp), .scr_link_mgmt_good(scr_link_mgmt_good),
   .scr_line(scr_line), .scr_port_ready(scr_port_ready), .scr_txd(scr_txd),
   .scr_rxd(scr_rxd), .scr_dtr(scr_dtr), .scr_rts(scr_rts)
);
`default_nettype wire

// ===== sil_status_indicator_tb.sv
// Self-checking testbench for the status indicator logic.
`timescale 1ns/1ps
`default_nettype none
module sil_status_indicator_tb;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] p0;
      logic [7:0] p1;
      logic [1:0] lan;
      logic rdy;
   } sil_row_type;
   logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fault_any = 1'b0;
   logic test_any = 1'b0, backup_up = 1'b0, backup_data = 1'b0, link_mgmt_good = 1'b1;
   logic lan_tx = 1'b0, lan_rx = 1'b0, power_lamp, alarm_lamp, test_active_lamp, backup_lamp;
   logic frame_relay_mode_lamp, mode_lamp_green, port_ready_lamp, scr_frame_relay_mode;
   logic scr_link_mgmt_good, scr_port_ready, scr_txd, scr_rxd, scr_dtr, scr_rts;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rdat;
   sil_pkg::sil_line_type [1:0] line_cond = '0;
   sil_pkg::sil_port_type port0 = '0, port1 = '0;
   sil_pkg::sil_line_lamp_type [1:0] line_lamp, scr_line;
   int bad_count = 0, compares = 0, cyc = 0, hits;
   sil_row_type rows [11] = '{
      '{8'h01, 8'hC0, 8'h00, 2'h0, 1'h1}, '{8'h01, 8'h40, 8'h00, 2'h0, 1'h0},
      '{8'h01, 8'hE4, 8'h00, 2'h0, 1'h0}, '{8'h01, 8'hD4, 8'h00, 2'h0, 1'h1},
      '{8'h01, 8'hF8, 8'h00, 2'h0, 1'h0}, '{8'h03, 8'hC0, 8'h00, 2'h0, 1'h1},
      '{8'h03, 8'h00, 8'hC0, 2'h0, 1'h1}, '{8'h03, 8'hC0, 8'h80, 2'h0, 1'h0},
      '{8'h03, 8'hC0, 8'hC0, 2'h0, 1'h1}, '{8'h05, 8'h00, 8'h00, 2'h3, 1'h1},
      '{8'h05, 8'h00, 8'h00, 2'h2, 1'h0}};
   sil_status_indicator #(.NLINE(2), .BLINK_HALF(4), .OOF_PERIOD(8)) dut (.*);
   always #25 mclk = ~mclk;
   task automatic test_done();
      $display("compares %0d errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   initial begin
      wait_n(12);
      chk({power_lamp, alarm_lamp, test_active_lamp, backup_lamp}, 8'h04);
      @(posedge mclk);
      reset <= 1'b0;
      rd(4'h0, rdat);
      chk(rdat, sil_pkg::CTRL_RESET);
      wr(4'h3, 8'h5A);
      rd(4'h3, rdat);
      chk(rdat, 8'h5A);
      wr(4'h9, 8'hFF);
      rd(4'h9, rdat);
      chk(rdat, 8'h00);
      chk(alarm_lamp, 8'h01);
      wr(4'h0, 8'h21);
      wait_n(2);
      chk({power_lamp, alarm_lamp}, 8'h02);
      @(posedge mclk);
      fault_any <= 1'b1;
      wait_n(2);
      chk(alarm_lamp, 8'h01);
      @(posedge mclk);
      fault_any <= 1'b0;
      wr(4'h0, 8'h11);
      wait_n(2);
      chk(power_lamp, 8'h00);
      for (int i = 1; i >= 0; i--) begin
         @(posedge mclk);
         test_any <= i[0];
         wait_n(2);
         chk(test_active_lamp, 8'(i[0]));
      end
      for (int m = 0; m < 3; m++) begin
         @(posedge mclk);
         backup_up <= m < 2;
         backup_data <= m == 0;
         wait_n(2);
         hits = 0;
         repeat (16) begin
            wait_n(1);
            hits += backup_lamp;
         end
         chk(8'(hits), m == 0 ? 8'h10 : m == 1 ? 8'h08 : 8'h00);
      end
      wr(4'h0, 8'h0B);
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         link_mgmt_good <= i[0];
         wait_n(2);
         chk({frame_relay_mode_lamp, mode_lamp_green, scr_frame_relay_mode, scr_link_mgmt_good},
            {4'h0, !i[0], i[0], 1'b1, i[0]});
      end
      wr(4'h0, 8'h03);
      wait_n(2);
      chk(scr_frame_relay_mode, 8'h00);
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         line_cond[0] <= 6'h01 << i;
         wait_n(2);
         chk({line_lamp[0].sig, line_lamp[0].alm, line_lamp[1].alm}, {i != 5, 2'h2});
      end
      @(posedge mclk);
      line_cond[0] <= '0;
      wait_n(20);
      chk(line_lamp[0].oof, 8'h00);
      @(posedge mclk);
      line_cond[0].oof <= 1'b1;
      @(posedge mclk);
      line_cond[0].oof <= 1'b0;
      hits = 0;
      repeat (32) begin
         wait_n(1);
         hits += line_lamp[0].oof;
      end
      chk(8'(hits), 8'h08);
      foreach (rows[k]) begin
         wr(4'h0, rows[k].ctrl);
         @(posedge mclk);
         port0 <= rows[k].p0;
         port1 <= rows[k].p1;
         {lan_tx, lan_rx} <= rows[k].lan;
         wait_n(2);
         chk(port_ready_lamp, rows[k].rdy);
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         port0 <= i[0] ? 8'h0A : 8'h05;
         wait_n(2);
         chk({scr_txd, scr_rxd, scr_dtr, scr_rts}, i[0] ? 8'h0A : 8'h05);
      end
      rd(4'h2, rdat);
      chk(rdat, 8'h80);
      rd(4'h1, rdat);
      chk(rdat, 8'h04);
      @(posedge mclk);
      reset <= 1'b1;
      wait_n(2);
      chk({power_lamp, alarm_lamp, port_ready_lamp, scr_txd}, 8'h04);
      @(posedge mclk);
      reset <= 1'b0;
      wait_n(2);
      chk(alarm_lamp, 8'h01);
      rd(4'h1, rdat);
      chk(rdat, 8'h84);
      test_done();
   end
endmodule
`default_nettype wire
